/* design/tia_pkg.sv */
package tia_pkg;
  // Register offsets on the host port
  localparam logic [2:0] OFS_DATA = 3'h0;
  localparam logic [2:0] OFS_ADDR = 3'h1;
  localparam logic [2:0] OFS_CMD  = 3'h2;
  localparam logic [2:0] OFS_MODE = 3'h3;
  localparam logic [2:0] OFS_STAT = 3'h4;
  localparam logic [2:0] OFS_IFM1 = 3'h5;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] IFM1_RST = 8'h00;
  // Field positions
  localparam int OM_HI    = 7;
  localparam int OM_LO    = 6;
  localparam int COS_BIT  = 3;
  localparam int CSB_BIT  = 1;
  localparam int CSS_BIT  = 0;
  localparam int BUSY_BIT = 0;
  localparam int UD_BIT   = 7;
  localparam int RWS_BIT  = 7;
  // Operation modes
  localparam logic [1:0] OM_CMRST = 2'h0;
  localparam logic [1:0] OM_TEST  = 2'h1;
  localparam logic [1:0] OM_INIT  = 2'h2;
  localparam logic [1:0] OM_NORM  = 2'h3;
  // Command classes and codes
  localparam logic [3:0] MOC_TS_ONE = 4'hC;
  localparam logic [3:0] MOC_TS_ALL = 4'hD;
  localparam logic [2:0] CLS_CM_ALL = 3'h7;
  localparam logic [2:0] CLS_CM_COD = 3'h5;
  localparam logic [7:0] CMD_CM_CLR = 8'h70;
  localparam logic [3:0] CODE_UNASG = 4'h0;
  localparam logic [3:0] CODE_PROC  = 4'hC;
  localparam logic [3:0] CODE_PRE   = 4'hD;
  // Sizes and timing, times in ns
  localparam int CM_N        = 256;
  localparam int DM_N        = 128;
  localparam int CLK_NS      = 100;
  localparam int ACC_NORM_NS = 950;
  localparam int ACC_INIT_NS = 250;
  localparam int ACC_NORM_CYC = ACC_NORM_NS / CLK_NS;
  localparam int ACC_INIT_CYC = ACC_INIT_NS / CLK_NS;
  localparam int CM_CLR_CYC  = 256;
  localparam int TS_INIT_CYC = 1035;

  typedef struct packed {
    logic [3:0] code;
    logic [7:0] data;
  } tia_cm_s;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_SWEEP} tia_state_e;

  // Sub-slot write mask from operation code
  function automatic logic [7:0] tia_sub_mask(input logic [3:0] moc);
    case (moc)
      4'h1:    tia_sub_mask = 8'hFF;
      4'h3:    tia_sub_mask = 8'hF0;
      4'h2:    tia_sub_mask = 8'h0F;
      4'h7:    tia_sub_mask = 8'hC0;
      4'h6:    tia_sub_mask = 8'h30;
      4'h5:    tia_sub_mask = 8'h0C;
      4'h4:    tia_sub_mask = 8'h03;
      default: tia_sub_mask = 8'h00;
    endcase
  endfunction
endpackage

/* design/tia_top.sv */
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/100ps
// Notes on behaviour
// RL1: Standby floats interface outputs, stops clocks
// RL2: Operational outputs follow control memory entries
// RL3: Open drain sends ones on unassigned
// RL4: Push-pull drives; unassigned slots float
// RL5: Control memory: code and data per slot
// RL6: Data field is pointer, buffer or data
// RL7: Data memory: upstream code+data, downstream data
// RL8: Address top bit selects direction
// RL9: Code fields use low data nibble
// RL10: Command encodes memory, field, direction
// RL11: Command write launches; busy until done
// RL12: Host leaves registers alone while busy
// RL13: Normal single access within 9.5 cycles
// RL14: Reset mode clears memory in 256
// RL15: Clear command copies data, code unassigned
// RL16: Host clears control memory after reset
// RL17: Init mode access within 2.5 cycles
// RL18: Normal mode; tristate init 1035 cycles
// RL19: Test mode hits all locations
// RL20: Idle code repeats every frame
// RL21: Sub-slot writes leave others intact
// RL22: Downstream data read-only, shows received
// RL23: Operation code selects sub-slot
// RL24: Data reads return all eight bits
// RL25: Busy rises the cycle after command
module tia_top
  import tia_pkg::*;
#(
  parameter int NORM_CYC = ACC_NORM_CYC,
  parameter int INIT_CYC = ACC_INIT_CYC
) (
  input  wire logic       CLK_SYS_IN,
  input  wire logic       RST_N_IN,
  input  wire logic [2:0] ADDR_IN,
  input  wire logic [7:0] WDATA_IN,
  input  wire logic       WR_IN,
  input  wire logic       RD_IN,
  output logic      [7:0] RDATA_OUT,
  input  wire logic [6:0] CFI_SLOT_IN,
  input  wire logic [7:0] CFI_RX_IN,
  output logic      [7:0] CFI_DAT_OUT,
  output logic      [7:0] CFI_OE_OUT,
  output logic            DCLK_OUT,
  output logic            DCLK_OE_OUT,
  output logic            FSYNC_OUT,
  output logic            FSYNC_OE_OUT,
  input  wire logic [6:0] PCM_SLOT_IN,
  input  wire logic [7:0] PCM_RX_IN,
  output logic      [7:0] PCM_TX_OUT,
  output logic      [7:0] PCM_OE_OUT
);

  if (NORM_CYC < 1 || NORM_CYC > 15 || INIT_CYC < 1 || INIT_CYC > NORM_CYC) begin : g_chk
    $error("access cycle counts out of range");
  end

  // Storage, not reset: host clears it after power-up
  tia_cm_s    cm_mem  [CM_N]; // [RL5]
  logic [7:0] dmu_mem [DM_N]; // [RL7]
  logic [3:0] dmt_mem [DM_N]; // [RL7]
  logic [7:0] dmd_mem [DM_N]; // [RL7]

  logic [7:0] memory_access_data_reg;
  logic [7:0] memory_access_address_reg;
  logic [7:0] memory_access_command_reg;
  logic [7:0] operation_mode_control_reg;
  logic [7:0] ifm1_reg;
  logic [7:0] rdat_reg;
  tia_state_e st_reg;
  tia_state_e st_next;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic [7:0] idx_reg;
  logic [7:0] idx_next;
  logic [7:0] cfi_dat_reg;
  logic [7:0] cfi_oe_reg;
  logic [7:0] pcm_tx_reg;
  logic [7:0] pcm_oe_reg;
  logic       dcl_reg;
  logic       fsc_reg;
  logic       dcl_oe_reg;
  logic       fsc_oe_reg;

  wire        busy    = (st_reg != ST_IDLE);
  wire        wr_ok   = WR_IN && !busy; // [RL12]
  wire        cmd_wr  = wr_ok && (ADDR_IN == OFS_CMD);
  wire [7:0]  cmd_v   = cmd_wr ? WDATA_IN : memory_access_command_reg;
  wire        read_write_select     = cmd_v[RWS_BIT];
  wire [3:0]  moc     = cmd_v[6:3];
  wire [2:0]  cls     = cmd_v[6:4];
  wire        is_cm   = (cls == CLS_CM_ALL) || (cls == CLS_CM_COD); // [RL10]
  wire        cm_cod  = (cls == CLS_CM_COD);
  wire        is_ts   = !is_cm && ((moc == MOC_TS_ONE) || (moc == MOC_TS_ALL));
  wire [1:0]  om      = operation_mode_control_reg[OM_HI:OM_LO];
  wire        op_run  = (om == OM_NORM) || (om == OM_TEST); // [RL14] [RL17] [RL18] [RL19]
  wire        interface_standby_bit     = operation_mode_control_reg[CSB_BIT];
  wire        driver_type_bit     = operation_mode_control_reg[COS_BIT];
  wire        clock_source_select     = ifm1_reg[CSS_BIT];
  // Sweeps only for writes; reads always take one location
  wire        go_all  = !read_write_select && ((om == OM_CMRST) || (om == OM_TEST)
                        || (is_ts && moc == MOC_TS_ALL)); // [RL14] [RL19]
  wire [7:0]  last_ix = is_cm ? 8'(CM_N - 1) : 8'(DM_N - 1);
  wire [3:0]  one_len = (om == OM_INIT) ? 4'(INIT_CYC) : 4'(NORM_CYC); // [RL13] [RL17]
  wire        fire    = ((st_reg == ST_WAIT) && (cnt_reg == 4'h1)) || (st_reg == ST_SWEEP);
  wire [7:0]  acc_ix  = (st_reg == ST_SWEEP) ? idx_reg : memory_access_address_reg;
  wire [6:0]  dm_ix   = acc_ix[6:0];

  // Host side memory operations
  wire        cm_we   = fire && is_cm && !read_write_select;
  tia_cm_s    cm_cur;
  tia_cm_s    cm_wd;
  assign cm_cur = cm_mem[acc_ix];
  assign cm_wd  = '{code: cmd_v[3:0], data: cm_cod ? cm_cur.data : memory_access_data_reg}; // [RL15] [RL10]
  wire        ts_we   = fire && is_ts && !read_write_select;
  wire        hst_dmw = fire && !is_cm && !is_ts && !read_write_select; // [RL22]
  wire [7:0]  wmask   = tia_sub_mask(moc); // [RL23]
  wire [7:0]  dm_merge = (dmu_mem[dm_ix] & ~wmask) | (memory_access_data_reg & wmask); // [RL21]
  wire [7:0]  rd_val  = is_cm ? (cm_cod ? {4'h0, cm_cur.code} : cm_cur.data)
                      : is_ts ? {4'h0, dmt_mem[dm_ix]}
                      : (memory_access_address_reg[UD_BIT] ? dmu_mem[dm_ix] : dmd_mem[dm_ix]); // [RL8] [RL24]

  // Interface receive path, kept alive in standby
  tia_cm_s    ent_dn;
  tia_cm_s    ent_up;
  assign ent_dn = cm_mem[{1'b0, CFI_SLOT_IN}];
  assign ent_up = cm_mem[{1'b1, CFI_SLOT_IN}];
  wire        up_sw   = (ent_up.code != CODE_UNASG) && (ent_up.code != CODE_PROC)
                        && (ent_up.code != CODE_PRE);
  wire        cfi_uw  = op_run && up_sw && !hst_dmw; // [RL1] [RL6]
  wire        dmu_we  = hst_dmw || cfi_uw;
  wire [6:0]  dmu_wi  = hst_dmw ? dm_ix : ent_up.data[6:0];
  wire [7:0]  dmu_wd  = hst_dmw ? dm_merge : CFI_RX_IN;

  // Interface transmit value per slot
  wire        dn_una  = (ent_dn.code == CODE_UNASG);
  wire        dn_buf  = (ent_dn.code == CODE_PROC) || (ent_dn.code == CODE_PRE);
  wire [7:0]  dn_val  = dn_una ? 8'hFF
                      : dn_buf ? ent_dn.data
                      : dmd_mem[ent_dn.data[6:0]]; // [RL6]
  wire        cfi_on  = interface_standby_bit && op_run;
  wire [7:0]  oe_val  = !cfi_on ? 8'h00
                      : driver_type_bit ? ~dn_val
                      : (dn_una ? 8'h00 : 8'hFF); // [RL1] [RL2] [RL3] [RL4]
  wire        clk_on  = interface_standby_bit && op_run && !clock_source_select;

  // PCM transmit: idle code held until overwritten
  wire [3:0]  ts_cur  = dmt_mem[PCM_SLOT_IN];
  wire [7:0]  ts_exp  = {{2{ts_cur[3]}}, {2{ts_cur[2]}}, {2{ts_cur[1]}}, {2{ts_cur[0]}}};

  wire [7:0]  rd_mux  = (ADDR_IN == OFS_DATA) ? memory_access_data_reg
                      : (ADDR_IN == OFS_ADDR) ? memory_access_address_reg
                      : (ADDR_IN == OFS_CMD)  ? memory_access_command_reg
                      : (ADDR_IN == OFS_MODE) ? operation_mode_control_reg
                      : (ADDR_IN == OFS_STAT) ? (8'(busy) << BUSY_BIT)
                      : (ADDR_IN == OFS_IFM1) ? ifm1_reg
                      : 8'h00;

  always_comb begin
    st_next  = st_reg;
    cnt_next = cnt_reg;
    idx_next = idx_reg;
    case (st_reg)
      ST_IDLE: begin
        if (cmd_wr && go_all) begin // [RL11] [RL25]
          st_next  = ST_SWEEP;
          idx_next = 8'h00;
        end else if (cmd_wr) begin
          st_next  = ST_WAIT;
          cnt_next = one_len;
        end
      end
      ST_WAIT: begin
        cnt_next = cnt_reg - 4'h1;
        if (cnt_reg == 4'h1) begin
          st_next = ST_IDLE; // [RL11]
        end
      end
      ST_SWEEP: begin
        idx_next = idx_reg + 8'h01;
        if (idx_reg == last_ix) begin
          st_next = ST_IDLE; // [RL14] [RL18]
        end
      end
      default: st_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      st_reg  <= ST_IDLE;
      cnt_reg <= 4'h0;
      idx_reg <= 8'h00;
    end else begin
      st_reg  <= st_next;
      cnt_reg <= cnt_next;
      idx_reg <= idx_next;
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      memory_access_data_reg <= 8'h00;
      memory_access_address_reg <= 8'h00;
      memory_access_command_reg <= 8'h00;
      operation_mode_control_reg <= MODE_RST;
      ifm1_reg <= IFM1_RST;
      rdat_reg <= 8'h00;
    end else begin
      if (wr_ok && ADDR_IN == OFS_DATA) begin
        memory_access_data_reg <= WDATA_IN;
      end else if (fire && read_write_select) begin
        memory_access_data_reg <= rd_val; // [RL24]
      end
      if (wr_ok && ADDR_IN == OFS_ADDR) begin
        memory_access_address_reg <= WDATA_IN;
      end
      if (cmd_wr) begin
        memory_access_command_reg <= WDATA_IN;
      end
      if (WR_IN && ADDR_IN == OFS_MODE) begin
        operation_mode_control_reg <= WDATA_IN;
      end
      if (WR_IN && ADDR_IN == OFS_IFM1) begin
        ifm1_reg <= WDATA_IN;
      end
      rdat_reg <= RD_IN ? rd_mux : 8'h00;
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (cm_we) begin
      cm_mem[acc_ix] <= cm_wd; // [RL15]
    end
    if (ts_we) begin
      dmt_mem[dm_ix] <= memory_access_data_reg[3:0]; // [RL9]
    end
    if (dmu_we) begin
      dmu_mem[dmu_wi] <= dmu_wd; // [RL21]
    end
    if (op_run) begin
      dmd_mem[PCM_SLOT_IN] <= PCM_RX_IN; // [RL22]
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      cfi_dat_reg <= 8'h00;
      cfi_oe_reg  <= 8'h00;
      pcm_tx_reg  <= 8'h00;
      pcm_oe_reg  <= 8'h00;
      dcl_reg     <= 1'b0;
      fsc_reg     <= 1'b0;
      dcl_oe_reg  <= 1'b0;
      fsc_oe_reg  <= 1'b0;
    end else begin
      cfi_dat_reg <= cfi_on ? dn_val : 8'h00; // [RL2]
      cfi_oe_reg  <= oe_val;
      pcm_tx_reg  <= op_run ? dmu_mem[PCM_SLOT_IN] : 8'h00; // [RL20]
      pcm_oe_reg  <= op_run ? ts_exp : 8'h00;
      dcl_reg     <= clk_on ? !dcl_reg : 1'b0; // [RL1] [RL2]
      fsc_reg     <= clk_on && (CFI_SLOT_IN == 7'h00);
      dcl_oe_reg  <= clk_on; // [RL1] [RL2]
      fsc_oe_reg  <= clk_on; // [RL1] [RL2]
    end
  end

  assign RDATA_OUT    = rdat_reg;
  assign CFI_DAT_OUT  = cfi_dat_reg;
  assign CFI_OE_OUT   = cfi_oe_reg;
  assign PCM_TX_OUT   = pcm_tx_reg;
  assign PCM_OE_OUT   = pcm_oe_reg;
  assign DCLK_OUT     = dcl_reg;
  assign FSYNC_OUT    = fsc_reg;
  // Clock pins driven only as outputs, released in standby
  assign DCLK_OE_OUT  = dcl_oe_reg;
  assign FSYNC_OE_OUT = fsc_oe_reg;

  // Checking helpers
  logic [10:0] bcnt_reg;
  logic        swcm_reg;
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      bcnt_reg <= 11'h000;
      swcm_reg <= 1'b0;
    end else begin
      bcnt_reg <= busy ? bcnt_reg + 11'h001 : 11'h000;
      swcm_reg <= cmd_wr ? (WDATA_IN[6:4] == CLS_CM_ALL || WDATA_IN[6:4] == CLS_CM_COD)
                         : swcm_reg;
    end
  end

  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RST_N_IN);

  a_busy_rise: assert property (cmd_wr |=> busy) // [RL11] [RL25]
    else $error("busy did not rise after command");
  a_norm_time: assert property (st_reg == ST_WAIT && om == OM_NORM |-> bcnt_reg < 11'(NORM_CYC))
    else $error("normal access too long"); // [RL13]
  a_init_time: assert property (st_reg == ST_WAIT && om == OM_INIT |-> bcnt_reg < 11'(INIT_CYC))
    else $error("init access too long"); // [RL17]
  a_clr_time: assert property (st_reg == ST_SWEEP && swcm_reg |-> bcnt_reg < 11'(CM_CLR_CYC))
    else $error("memory clear too long"); // [RL14]
  a_ts_time: assert property (st_reg == ST_SWEEP |-> bcnt_reg < 11'(TS_INIT_CYC))
    else $error("tristate sweep too long"); // [RL18]
  a_clr_value: assert property (cm_we && memory_access_command_reg == CMD_CM_CLR |=>
      cm_mem[$past(acc_ix)] == {CODE_UNASG, $past(memory_access_data_reg)})
    else $error("clear wrote wrong value"); // [RL15]
  a_standby_float: assert property (!interface_standby_bit |=> CFI_OE_OUT == 8'h00 && !DCLK_OUT && !FSYNC_OUT)
    else $error("standby still drives"); // [RL1]
  a_od_unasg: assert property (cfi_on && driver_type_bit && dn_una |=>
      CFI_DAT_OUT == 8'hFF && CFI_OE_OUT == 8'h00)
    else $error("open drain unassigned not one"); // [RL3]
  a_pp_unasg: assert property (cfi_on && !driver_type_bit |=> CFI_OE_OUT == ($past(dn_una) ? 8'h00 : 8'hFF))
    else $error("push-pull enable wrong"); // [RL4]
  a_sub_keep: assert property (hst_dmw |=> (dmu_mem[$past(dm_ix)] & ~$past(wmask))
      == ($past(dmu_mem[dm_ix]) & ~$past(wmask)))
    else $error("sub-slot write touched other bits"); // [RL21]
  a_read_full: assert property (fire && read_write_select && !is_cm && !is_ts |=>
      memory_access_data_reg == ($past(memory_access_address_reg[UD_BIT]) ? $past(dmu_mem[dm_ix]) : $past(dmd_mem[dm_ix])))
    else $error("data read wrong"); // [RL8] [RL24]
  a_pcm_rx: assert property (op_run |=> dmd_mem[$past(PCM_SLOT_IN)] == $past(PCM_RX_IN))
    else $error("received slot not stored"); // [RL22]

  c_cm_clear: cover property (cm_we && memory_access_command_reg == CMD_CM_CLR && idx_reg == 8'hFF);
  c_ts_all: cover property (ts_we && st_reg == ST_SWEEP && idx_reg == 8'h7F);
  c_dm_read: cover property (fire && read_write_select && !is_cm && !is_ts);
  c_standby: cover property (op_run && !interface_standby_bit && up_sw);

endmodule

/* dv/tia_host.sv */
`timescale 1ns/100ps
module tia_host
  import tia_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic [7:0] rdata_in,
  output logic      [2:0] addr_out,
  output logic      [7:0] wdata_out,
  output logic            wr_out,
  output logic            rd_out
);
  initial begin
    addr_out  = 3'h0;
    wdata_out = 8'h00;
    wr_out    = 1'b0;
    rd_out    = 1'b0;
  end

  // Released lines get the inverse so stale values never look valid
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_out  <= a;
    wdata_out <= d;
    wr_out    <= 1'b1;
    @(posedge clk_in);
    wr_out    <= 1'b0;
    addr_out  <= ~a;
    wdata_out <= ~d;
  endtask

  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    rd_out   <= 1'b1;
    @(posedge clk_in);
    rd_out   <= 1'b0;
    addr_out <= ~a;
    #1;
    d = rdata_in;
  endtask

  // Poll busy before any new access; bounded so a stuck flag cannot hang
  task automatic wait_idle(output int n, output logic first);
    logic [7:0] s;
    n     = 0;
    first = 1'b0;
    do begin
      rd_reg(OFS_STAT, s);
      if (n == 0) begin
        first = s[BUSY_BIT];
      end
      n++;
    end while (s[BUSY_BIT] !== 1'b0 && n < 2000);
  endtask

  task automatic mem_cmd(input logic [7:0] ad, input logic [7:0] c, output int n,
                         output logic first);
    wr_reg(OFS_ADDR, ad);
    wr_reg(OFS_CMD, c);
    wait_idle(n, first);
  endtask
endmodule

/* dv/testbench.sv */
`timescale 1ns/100ps
module testbench
  import tia_pkg::*;
;
  logic       clk_sys;
  logic       rst_n;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic [6:0] cfi_slot;
  logic [7:0] cfi_rx;
  logic [7:0] cfi_dat;
  logic [7:0] cfi_oe;
  logic       dclk;
  logic [6:0] pcm_slot;
  logic [7:0] pcm_rx;
  logic [7:0] pcm_tx;
  logic [7:0] pcm_oe;
  int         fails;
  int         checks_done;
  logic [31:0] seed = 32'd73;
  logic [3:0] ops [7] = '{4'h1, 4'h3, 4'h2, 4'h7, 4'h6, 4'h5, 4'h4};

  tia_top u_tia_top (.CLK_SYS_IN(clk_sys), .RST_N_IN(rst_n), .ADDR_IN(addr),
    .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .CFI_SLOT_IN(cfi_slot),
    .CFI_RX_IN(cfi_rx), .CFI_DAT_OUT(cfi_dat), .CFI_OE_OUT(cfi_oe), .DCLK_OUT(dclk),
    .DCLK_OE_OUT(), .FSYNC_OUT(), .FSYNC_OE_OUT(), .PCM_SLOT_IN(pcm_slot),
    .PCM_RX_IN(pcm_rx), .PCM_TX_OUT(pcm_tx), .PCM_OE_OUT(pcm_oe));
  tia_host u_tia_host (.clk_in(clk_sys), .rdata_in(rdata), .addr_out(addr),
    .wdata_out(wdata), .wr_out(wr), .rd_out(rd));

  function automatic logic [7:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction

  function automatic logic [7:0] mask_of(input logic [3:0] op);
    case (op)
      4'h1:    return 8'hFF;
      4'h3:    return 8'hF0;
      4'h2:    return 8'h0F;
      4'h7:    return 8'hC0;
      4'h6:    return 8'h30;
      4'h5:    return 8'h0C;
      default: return 8'h03;
    endcase
  endfunction

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_le(input string nm, input int lim, input int n);
    checks_done++;
    if (n > lim) begin
      fails++;
      $display("ERROR %s expected <=%0d seen %0d", nm, lim, n);
    end
  endtask

  task automatic tally_and_finish();
    $display("Checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Two edges so the registered outputs settle whatever step we start in
  task automatic drive_cfi(input logic [6:0] sl);
    @(posedge clk_sys);
    cfi_slot <= sl;
    cfi_rx   <= xs();
    repeat (2) @(posedge clk_sys);
    #1;
  endtask

  task automatic drive_pcm(input logic [6:0] sl, input logic [7:0] rx);
    @(posedge clk_sys);
    pcm_slot <= sl;
    pcm_rx   <= rx;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  initial begin
    #(100 * 20000);
    fails++;
    $display("ERROR watchdog expected done seen timeout");
    tally_and_finish();
  end

  initial begin
    logic [7:0] d, b, nv, e, p, q, r;
    int         n;
    logic       f;
    rst_n = 1'b0;
    cfi_slot = 7'h00;
    cfi_rx = 8'h00;
    pcm_slot = 7'h00;
    pcm_rx = 8'h00;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    u_tia_host.rd_reg(OFS_MODE, d);
    chk("mode reset", MODE_RST, d);
    u_tia_host.rd_reg(3'h7, d);
    chk("unmapped read", 8'h00, d);
    $display("TEST reset done");
    u_tia_host.wr_reg(OFS_DATA, 8'h00);
    u_tia_host.mem_cmd(xs(), CMD_CM_CLR, n, f);
    chk("busy at once", 8'h01, {7'h00, f});
    chk_le("clear polls", 129, n);
    u_tia_host.mem_cmd(8'h85, 8'hD0, n, f);
    u_tia_host.rd_reg(OFS_DATA, d);
    chk("code cleared", 8'h00, d);
    $display("TEST clear done");
    u_tia_host.wr_reg(OFS_MODE, 8'h80);
    p = xs() & 8'h7F;
    e = xs();
    u_tia_host.wr_reg(OFS_DATA, e);
    u_tia_host.mem_cmd(p, 8'h7C, n, f);
    chk_le("init access", 2, n);
    u_tia_host.wr_reg(OFS_MODE, 8'hC2);
    drive_cfi(p[6:0]);
    chk("processor data", e, cfi_dat);
    chk("push pull enable", 8'hFF, cfi_oe);
    d[0] = dclk;
    @(posedge clk_sys);
    #1;
    chk("data clock runs", {7'h00, ~d[0]}, {7'h00, dclk});
    drive_cfi(p[6:0] ^ 7'h01);
    chk("unassigned float", 8'h00, cfi_oe);
    u_tia_host.wr_reg(OFS_MODE, 8'hCA);
    drive_cfi(p[6:0] ^ 7'h01);
    chk("open drain ones", 8'hFF, cfi_dat);
    chk("open drain enable", 8'h00, cfi_oe);
    u_tia_host.wr_reg(OFS_MODE, 8'hC8);
    drive_cfi(p[6:0]);
    chk("standby float", 8'h00, cfi_oe);
    chk("standby clock", 8'h00, {7'h00, dclk});
    @(posedge clk_sys);
    #1;
    chk("standby clock still", 8'h00, {7'h00, dclk});
    $display("TEST interface done");
    u_tia_host.wr_reg(OFS_MODE, 8'hC2);
    p = xs() | 8'h80;
    for (int i = 0; i < 7; i++) begin
      b = xs();
      nv = xs();
      u_tia_host.wr_reg(OFS_DATA, b);
      u_tia_host.mem_cmd(p, 8'h08, n, f);
      u_tia_host.wr_reg(OFS_DATA, nv);
      u_tia_host.mem_cmd(p, {1'b0, ops[i], 3'h0}, n, f);
      u_tia_host.mem_cmd(p, 8'h80, n, f);
      chk_le("read access", 5, n);
      u_tia_host.rd_reg(OFS_DATA, d);
      e = (b & ~mask_of(ops[i])) | (nv & mask_of(ops[i]));
      chk("sub slot write", e, d);
    end
    u_tia_host.wr_reg(OFS_DATA, 8'hF5);
    u_tia_host.mem_cmd(p, 8'h60, n, f);
    u_tia_host.mem_cmd(p, 8'hE0, n, f);
    u_tia_host.rd_reg(OFS_DATA, d);
    chk("code nibble", 8'h05, d);
    drive_pcm(p[6:0] ^ 7'h01, pcm_rx);
    drive_pcm(p[6:0], pcm_rx);
    chk("idle code sent", e, pcm_tx);
    chk("tristate enable", 8'h33, pcm_oe);
    $display("TEST data memory done");
    r = xs();
    q = xs() & 8'h7F;
    drive_pcm(q[6:0], r);
    u_tia_host.mem_cmd(q, 8'h80, n, f);
    u_tia_host.rd_reg(OFS_DATA, d);
    chk("received slot", r, d);
    $display("TEST downstream done");
    u_tia_host.wr_reg(OFS_MODE, 8'h42);
    e = xs();
    u_tia_host.wr_reg(OFS_DATA, e);
    u_tia_host.mem_cmd(xs() & 8'h7F, 8'h08, n, f);
    chk_le("broadcast polls", 65, n);
    for (int i = 0; i < 2; i++) begin
      u_tia_host.mem_cmd(p ^ (8'h15 * i), 8'h80, n, f);
      u_tia_host.rd_reg(OFS_DATA, d);
      chk("broadcast value", e, d);
    end
    $display("TEST test mode done");
    tally_and_finish();
  end
endmodule
